// *** verilog/xsd_pkg.sv ***
// Package: opcode patterns, flag masks, clock counts and register map of the decoder
package xsd_pkg;
    // ********************************************************
    // Opcode patterns
    // ********************************************************
    localparam logic [7:0] OP_ESC     = 8'h0F;
    localparam logic [6:0] OP_SHI_HI  = 7'h60;  // C[000w] without w
    localparam logic [5:0] OP_SBB_RM  = 6'h06;  // 1[10dw] without d,w
    localparam logic [6:0] OP_SBB_ACC = 7'h0E;  // 1[110w] without w
    localparam logic [5:0] OP_GRP_IMM = 6'h20;  // 8[00sw] without s,w
    localparam logic [6:0] OP_SCAN    = 7'h57;  // A[111w] without w
    localparam logic [3:0] OP_SET_HI  = 4'h9;   // 0F 9x upper nibble
    localparam logic [2:0] REG_SAR    = 3'h7;
    localparam logic [2:0] REG_SBB    = 3'h3;
    localparam logic [2:0] REG_SET    = 3'h0;
    localparam logic [1:0] MOD_REG    = 2'h3;

    // ********************************************************
    // Flag mask layout: OF DF IF TF SF ZF AF PF CF
    // ********************************************************
    localparam int unsigned NFLAG     = 9;
    localparam logic [8:0] FM_NONE    = 9'h000;
    localparam logic [8:0] FM_ARITH   = 9'h11F;  // OF SF ZF AF PF CF
    localparam logic [8:0] FM_SHIFT   = 9'h01B;  // SF ZF PF CF
    localparam logic [8:0] FM_SHIFT_U = 9'h104;  // OF AF undefined

    // ********************************************************
    // Clock counts on a cache hit
    // ********************************************************
    localparam logic [1:0] CLK_ONE    = 2'h1;
    localparam logic [1:0] CLK_TWO    = 2'h2;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_RETIRED = 4'h4;
    localparam logic [3:0]  ADDR_LAST    = 4'h8;
    localparam logic [1:0]  CTRL_RST     = 2'h1;  // enabled, real mode
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_PM_BIT  = 1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;

    typedef enum logic [2:0] {
        XSD_ILLEGAL = 3'h0,
        XSD_SAR_IMM = 3'h1,
        XSD_SBB_RR  = 3'h2,
        XSD_SBB_RM  = 3'h3,
        XSD_SBB_MR  = 3'h4,
        XSD_SBB_IMM = 3'h5,
        XSD_SBB_ACC = 3'h6,
        XSD_SETCC   = 3'h7
    } xsd_class_t;

    // Architectural arithmetic flags read by the byte-set family
    typedef struct packed {
        logic of;
        logic sf;
        logic zf;
        logic pf;
        logic cf;
    } xsd_flags_t;

    // First three bytes of an instruction, byte 0 first
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
    } xsd_fetch_t;

    typedef struct packed {
        xsd_class_t cls;
        logic       scan;      // string scan, decoded beside the table
        logic       wide;
        logic       dir;
        logic       sext;
        logic       prot;
        logic [3:0] cond;
        logic [7:0] set_byte;
        logic [8:0] flag_wr;
        logic [8:0] flag_undef;
        logic [1:0] clocks;
    } xsd_op_t;
endpackage : xsd_pkg

// *** verilog/xsd_decode.sv ***
// Decoder for subtract-with-borrow, arithmetic shift, string scan and byte-set opcodes
//
// Behaviour
// - C0/C1 with reg 111 is arithmetic right shift by immediate; 2 clocks, OF undefined.
// - Borrow subtract register/memory forms take 1 clock and write all six arithmetic flags.
// - 80-83 with reg 011 subtracts immediate with borrow; s selects sign extension; 1 clock.
// - 1C/1D subtract immediate with borrow from accumulator in 1 clock in both modes.
// - 0F 92 reg 000 sets byte on carry in 1 clock, flags untouched.
// - 0F 96 sets byte on below-or-equal in 1 clock, flags untouched.
// - 0F 9C sets byte on signed less in 1 clock, flags untouched.
// - 0F 9E sets byte on signed less-or-equal in 1 clock, flags untouched.
// - 0F 93 sets byte on no carry in 1 clock, flags untouched.
// - 0F 97 sets byte on above in 1 clock, flags untouched.
// - 0F 95 sets byte on not zero in 1 clock, flags untouched.
// - 0F 9D sets byte on signed greater-or-equal in 1 clock, flags untouched.
// - 0F 9F sets byte on signed greater in 1 clock, flags untouched.
// - 0F 91 sets byte on no overflow in 1 clock, flags untouched.
// - 0F 9B sets byte on parity odd in 1 clock, flags untouched.
// - 0F 99 sets byte on not sign in 1 clock, flags untouched.
// - 0F 90 sets byte on overflow in 1 clock, flags untouched.
// - 0F 9A sets byte on parity even in 1 clock, flags untouched.
// - 0F 98 sets byte on sign in 1 clock, flags untouched.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module xsd_decode (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_reset,
    // Fetch side
    input  wire logic               i_ins_valid,
    input  wire xsd_pkg::xsd_fetch_t i_ins,
    input  wire xsd_pkg::xsd_flags_t i_flags,
    output logic                    o_ins_ready,
    // Execution side
    output logic                    o_res_valid,
    output xsd_pkg::xsd_op_t        o_res,
    // AXI4-Lite write
    input  wire logic [3:0]         i_awaddr,
    input  wire logic               i_awvalid,
    output logic                    o_awready,
    input  wire logic [31:0]        i_wdata,
    input  wire logic [3:0]         i_wstrb,
    input  wire logic               i_wvalid,
    output logic                    o_wready,
    output logic [1:0]              o_bresp,
    output logic                    o_bvalid,
    input  wire logic               i_bready,
    // AXI4-Lite read
    input  wire logic [3:0]         i_araddr,
    input  wire logic               i_arvalid,
    output logic                    o_arready,
    output logic [31:0]             o_rdata,
    output logic [1:0]              o_rresp,
    output logic                    o_rvalid,
    input  wire logic               i_rready
);
    // ********************************************************
    // Condition evaluation
    // ********************************************************
    // Even codes test the condition, odd codes its inverse
    function automatic logic cond_true(input logic [3:0] cc, input xsd_pkg::xsd_flags_t f);
        logic base;
        base = 1'b0;
        unique case (cc[3:1])
            3'h0: base = f.of;
            3'h1: base = f.cf;
            3'h2: base = f.zf;
            3'h3: base = f.cf | f.zf;
            3'h4: base = f.sf;
            3'h5: base = f.pf;
            3'h6: base = f.sf ^ f.of;
            3'h7: base = f.zf | (f.sf ^ f.of);
        endcase
        return base ^ cc[0];
    endfunction : cond_true

    // ********************************************************
    // Control register
    // ********************************************************
    logic [1:0]  ctrl_q;
    logic [31:0] retired_q;
    wire  logic  enable = ctrl_q[xsd_pkg::CTRL_EN_BIT];
    wire  logic  prot   = ctrl_q[xsd_pkg::CTRL_PM_BIT];

    // ********************************************************
    // Opcode decode
    // ********************************************************
    wire logic [1:0] modf   = i_ins.b1[7:6];
    wire logic [2:0] regf   = i_ins.b1[5:3];
    wire logic [1:0] modf2  = i_ins.b2[7:6];
    wire logic [2:0] regf2  = i_ins.b2[5:3];
    wire logic is_sar  = (i_ins.b0[7:1] == xsd_pkg::OP_SHI_HI) && (regf == xsd_pkg::REG_SAR);
    wire logic is_sbrm = (i_ins.b0[7:2] == xsd_pkg::OP_SBB_RM);
    wire logic is_sbim = (i_ins.b0[7:2] == xsd_pkg::OP_GRP_IMM) && (regf == xsd_pkg::REG_SBB);
    wire logic is_sbac = (i_ins.b0[7:1] == xsd_pkg::OP_SBB_ACC);
    wire logic is_scan = (i_ins.b0[7:1] == xsd_pkg::OP_SCAN);
    // Other reg fields under the escape fall through as illegal
    // byte-set escape match
    wire logic is_set  = (i_ins.b0 == xsd_pkg::OP_ESC) && (i_ins.b1[7:4] == xsd_pkg::OP_SET_HI)
                         && (regf2 == xsd_pkg::REG_SET);
    wire logic [3:0] cc = i_ins.b1[3:0];
    wire logic set_hit = cond_true(cc, i_flags);
    wire logic unused  = ^{modf2};

    xsd_pkg::xsd_op_t dec;
    always_comb begin
        dec            = '0;
        dec.prot       = prot;
        dec.wide       = i_ins.b0[0];
        dec.clocks     = xsd_pkg::CLK_ONE;
        if (is_sar) begin
            dec.cls        = xsd_pkg::XSD_SAR_IMM;
            dec.flag_wr    = xsd_pkg::FM_SHIFT;
            dec.flag_undef = xsd_pkg::FM_SHIFT_U;
            dec.clocks     = xsd_pkg::CLK_TWO;
        end else if (is_sbrm) begin
            // mode 11 is register to register
            dec.dir     = i_ins.b0[1];
            dec.flag_wr = xsd_pkg::FM_ARITH;
            if (modf == xsd_pkg::MOD_REG) begin
                dec.cls = xsd_pkg::XSD_SBB_RR;
            end else if (i_ins.b0[1]) begin
                dec.cls = xsd_pkg::XSD_SBB_MR;
            end else begin
                dec.cls = xsd_pkg::XSD_SBB_RM;
            end
        end else if (is_sbim) begin
            dec.cls     = xsd_pkg::XSD_SBB_IMM;
            dec.sext    = i_ins.b0[1];
            dec.flag_wr = xsd_pkg::FM_ARITH;
        end else if (is_sbac) begin
            dec.cls     = xsd_pkg::XSD_SBB_ACC;
            dec.flag_wr = xsd_pkg::FM_ARITH;
        end else if (is_scan) begin
            dec.scan    = 1'b1;
            dec.flag_wr = xsd_pkg::FM_ARITH;
            dec.clocks  = xsd_pkg::CLK_TWO;
        end else if (is_set) begin
            dec.cls      = xsd_pkg::XSD_SETCC;
            dec.wide     = 1'b0;
            dec.cond     = cc;
            dec.set_byte = {7'h00, set_hit};
        end
    end

    // ********************************************************
    // Execution sequencer
    // ********************************************************
    // Gray order: done is one bit from idle and from execute; idle to execute flips both bits
    typedef enum logic [1:0] {
        XSD_IDLE = 2'h0,
        XSD_DONE = 2'h1,
        XSD_EXEC = 2'h3
    } xsd_state_t;

    xsd_state_t       state_q, state_d;
    xsd_pkg::xsd_op_t op_q;
    // A new instruction may be taken while the previous one retires
    assign o_ins_ready = enable && (state_q != XSD_EXEC);
    wire logic take    = i_ins_valid && o_ins_ready;
    wire logic two_clk = (dec.clocks == xsd_pkg::CLK_TWO);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            XSD_IDLE, XSD_DONE: begin
                if (take) begin
                    state_d = two_clk ? XSD_EXEC : XSD_DONE;
                end else begin
                    state_d = XSD_IDLE;
                end
            end
            XSD_EXEC: state_d = XSD_DONE;
            default:  state_d = XSD_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= XSD_IDLE;
            op_q    <= '0;
        end else begin
            state_q <= state_d;
            if (take) begin
                op_q <= dec;
            end
        end
    end

    assign o_res_valid = (state_q == XSD_DONE);
    assign o_res       = op_q;

    // ********************************************************
    // AXI4-Lite slave
    // ********************************************************
    // Register map decode, shared by both channels
    function automatic logic reg_hit(input logic [3:0] a);
        return (a == xsd_pkg::ADDR_CTRL) || (a == xsd_pkg::ADDR_RETIRED)
            || (a == xsd_pkg::ADDR_LAST);
    endfunction : reg_hit

    logic       aw_q, w_q, bvalid_q, rvalid_q;
    logic [3:0] awaddr_q;
    logic [1:0] wdat_q;
    logic       wlane_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q, bresp_q;
    logic [2:0]  last_q;

    assign o_awready = !aw_q && !bvalid_q;
    assign o_wready  = !w_q && !bvalid_q;
    assign o_arready = !rvalid_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    wire logic wr_go   = aw_q && w_q && !bvalid_q;
    wire logic ar_take = i_arvalid && o_arready;
    wire logic wr_map  = reg_hit(awaddr_q);
    wire logic [31:0] rd_mux =
        (i_araddr == xsd_pkg::ADDR_CTRL)    ? {30'h0, ctrl_q} :
        (i_araddr == xsd_pkg::ADDR_RETIRED) ? retired_q :
        (i_araddr == xsd_pkg::ADDR_LAST)    ? {29'h0, last_q} : 32'h0;
    wire logic rd_map  = reg_hit(i_araddr);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 4'h0;
            wdat_q   <= 2'h0;
            wlane_q  <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= xsd_pkg::RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_q     <= 1'b1;
                wdat_q  <= i_wdata[1:0];
                wlane_q <= i_wstrb[0];
            end
            if (wr_go) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_map ? xsd_pkg::RESP_OKAY : xsd_pkg::RESP_DECERR;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read data is registered so it stands still while rvalid waits for rready
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= xsd_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_map ? xsd_pkg::RESP_OKAY : xsd_pkg::RESP_DECERR;
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Retire counter and last class; only the control word is writable
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_q    <= xsd_pkg::CTRL_RST;
            retired_q <= 32'h0;
            last_q    <= 3'h0;
        end else begin
            if (wr_go && wlane_q && (awaddr_q == xsd_pkg::ADDR_CTRL)) begin
                ctrl_q <= wdat_q;
            end
            if (o_res_valid) begin
                retired_q <= retired_q + 32'h1;
                last_q    <= op_q.cls;
            end
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    AST_SAR_TWO_CLK: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_sar |=> !o_res_valid ##1 o_res_valid && o_res.cls == xsd_pkg::XSD_SAR_IMM)
        else $error("shift by immediate did not retire in two clocks");
    AST_SAR_FLAGS: assert property (@(posedge i_clk) disable iff (i_reset)
        o_res_valid && o_res.cls == xsd_pkg::XSD_SAR_IMM |->
            o_res.flag_wr == xsd_pkg::FM_SHIFT && o_res.flag_undef[8])
        else $error("shift flag masks wrong");
    AST_SBB_ONE_CLK: assert property (@(posedge i_clk) disable iff (i_reset)
        take && (is_sbrm || is_sbac) |=> o_res_valid && o_res.flag_wr == xsd_pkg::FM_ARITH)
        else $error("borrow subtract not retired in one clock with full flags");
    AST_SBB_RR_MODE: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_sbrm && modf == xsd_pkg::MOD_REG |=> o_res.cls == xsd_pkg::XSD_SBB_RR)
        else $error("register form of borrow subtract misclassified");
    AST_SBB_IMM_SEXT: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_sbim |=> o_res_valid && o_res.sext == $past(i_ins.b0[1]))
        else $error("immediate borrow subtract lost its sign-extend bit");
    AST_SBB_ACC_MODE: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_sbac |=> o_res_valid && o_res.prot == $past(prot))
        else $error("accumulator borrow subtract timing or mode wrong");
    AST_SET_NO_FLAGS: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_set |=> o_res_valid && o_res.flag_wr == xsd_pkg::FM_NONE
            && o_res.cls == xsd_pkg::XSD_SETCC)
        else $error("byte set touched flags or took too long");
    AST_SET_VALUE: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_set && cc == 4'h4 |=> o_res.set_byte == {7'h00, $past(i_flags.zf)})
        else $error("byte set on zero gave wrong value");
    AST_SET_BOOL: assert property (@(posedge i_clk) disable iff (i_reset)
        o_res_valid && o_res.cls == xsd_pkg::XSD_SETCC |-> o_res.set_byte[7:1] == 7'h00)
        else $error("byte set result not zero or one");
    AST_EXEC_STALL: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == XSD_EXEC |-> !o_ins_ready
            ##1 o_res_valid && o_res.clocks == xsd_pkg::CLK_TWO)
        else $error("fetch accepted during a two-clock execute");
    AST_SCAN_TWO_CLK: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_scan |=> !o_res_valid ##1 o_res_valid && o_res.scan)
        else $error("string scan did not retire in two clocks");
    AST_SBB_MEM_DIR: assert property (@(posedge i_clk) disable iff (i_reset)
        take && is_sbrm && modf != xsd_pkg::MOD_REG |=> o_res.cls ==
            ($past(i_ins.b0[1]) ? xsd_pkg::XSD_SBB_MR : xsd_pkg::XSD_SBB_RM))
        else $error("memory form of borrow subtract misclassified");
    AST_SET_BAD_REG: assert property (@(posedge i_clk) disable iff (i_reset)
        take && i_ins.b0 == xsd_pkg::OP_ESC && i_ins.b1[7:4] == xsd_pkg::OP_SET_HI
            && regf2 != xsd_pkg::REG_SET |=> o_res.cls == xsd_pkg::XSD_ILLEGAL)
        else $error("byte set with a nonzero reg field was accepted");
    AST_RETIRE_COUNT: assert property (@(posedge i_clk) disable iff (i_reset)
        o_res_valid |=> retired_q == $past(retired_q) + 32'h1)
        else $error("retired counter missed a completed instruction");
endmodule : xsd_decode

// *** verification/xsd_fetch_model.sv ***
// Fetch-side partner model that offers instructions and flags to the decoder
`timescale 1ns/10ps
module xsd_fetch_model (
    // Clock and handshake
    input  wire logic           i_clk,
    input  wire logic           i_ready,
    // Offered instruction
    output logic                o_valid,
    output xsd_pkg::xsd_fetch_t o_ins,
    output xsd_pkg::xsd_flags_t o_flags
);
    initial begin
        o_valid = 1'b0;
        o_ins   = '0;
        o_flags = '0;
    end

    // ********************************************************
    // Offer one instruction after gap + 1 idle cycles, hold until taken or 100 cycles pass
    // ********************************************************
    task automatic offer(input xsd_pkg::xsd_fetch_t ins, input xsd_pkg::xsd_flags_t fl,
                         input int gap, output int wait_n);
        wait_n = 0;
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_ins   <= ins;
        o_flags <= fl;
        do begin
            @(posedge i_clk);
            wait_n++;
        end while (i_ready !== 1'b1 && wait_n < 100);
        // Idle bytes flip so a stale opcode or flag cannot pass for a new one
        o_valid <= 1'b0;
        o_ins   <= ~ins;
        o_flags <= ~fl;
    endtask : offer
endmodule : xsd_fetch_model

// *** verification/xsd_decode_tb.sv ***
// Self-checking bench: decode classes, flag masks, clock counts and registers
`timescale 1ns/10ps
module xsd_decode_tb;
    int                  errors = 0;
    int                  tests_run = 0;
    logic                i_clk = 1'b0;
    logic                i_reset = 1'b1;
    logic                ins_valid, o_ins_ready, o_res_valid;
    xsd_pkg::xsd_fetch_t ins;
    xsd_pkg::xsd_flags_t flags;
    xsd_pkg::xsd_op_t    o_res;
    logic [3:0]          awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0]         wdata = 32'h0, o_rdata;
    logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                arvalid = 1'b0, rready = 1'b0;
    logic                o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]          o_bresp, o_rresp;

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    xsd_fetch_model fm_u (.i_clk(i_clk), .i_ready(o_ins_ready), .o_valid(ins_valid),
                          .o_ins(ins), .o_flags(flags));

    xsd_decode dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_ins_valid(ins_valid),
        .i_ins(ins), .i_flags(flags), .o_ins_ready(o_ins_ready),
        .o_res_valid(o_res_valid), .o_res(o_res), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata), .i_wstrb(wstrb),
        .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(rready));

    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (awvalid && o_awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && o_wready === 1'b1) wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1 && n < 100);
        r = o_bresp;
        bready <= 1'b0;
        chk(16'(n < 100), 16'h1, "write answer");
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (arvalid && o_arready === 1'b1) arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1 && n < 100);
        d = o_rdata;
        r = o_rresp;
        rready <= 1'b0;
        chk(16'(n < 100), 16'h1, "read answer");
    endtask : axi_rd

    // Offer one instruction, then judge ready and result latency in clocks
    task automatic run(input logic [7:0] b0, b1, b2, input xsd_pkg::xsd_flags_t fl,
                       input int clk_n);
        int w;
        int n;
        fm_u.offer({b0, b1, b2}, fl, 0, w);
        chk(16'(w < 100), 16'h1, "instruction taken");
        n = 0;
        #1;
        chk(16'(o_ins_ready), 16'(clk_n == 1), "ready after take");
        while (o_res_valid !== 1'b1 && n < 10) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(16'(n + 1), 16'(clk_n), "result latency");
        chk(16'(o_res.clocks), 16'(clk_n), "clock count");
    endtask : run

    function automatic logic cond_true(input logic [3:0] c, input xsd_pkg::xsd_flags_t f);
        logic t;
        case (c[3:1])
            3'h0: t = f.of;
            3'h1: t = f.cf;
            3'h2: t = f.zf;
            3'h3: t = f.cf | f.zf;
            3'h4: t = f.sf;
            3'h5: t = f.pf;
            3'h6: t = f.sf ^ f.of;
            default: t = f.zf | (f.sf ^ f.of);
        endcase
        return t ^ c[0];
    endfunction : cond_true

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_sar();
        for (int w = 0; w < 2; w++) begin
            run(8'hC0 | 8'(w), w ? 8'h38 : 8'hF8, 8'h05, 5'h1F, 2);
            chk(16'(o_res.cls), 16'(xsd_pkg::XSD_SAR_IMM), "shift class");
            chk(16'(o_res.flag_wr), 16'(xsd_pkg::FM_SHIFT), "shift flags");
            chk(16'(o_res.flag_undef[8]), 16'h1, "shift overflow undefined");
            chk(16'(o_res.wide), 16'(w), "shift width");
        end
        run(8'hC1, 8'hE8, 8'h05, 5'h00, 1);
        chk(16'(o_res.cls), 16'(xsd_pkg::XSD_ILLEGAL), "other shift rejected");
        run(8'hAE, 8'h00, 8'h00, 5'h00, 2);
        chk(16'(o_res.scan), 16'h1, "string scan");
        chk(16'(o_res.flag_wr), 16'(xsd_pkg::FM_ARITH), "scan flags");
        $display("test sar done");
    endtask : t_sar

    task automatic t_sbb();
        logic [1:0]  r;
        logic [18:0] tbl [13] = '{{8'h18, 8'hC1, 3'h2}, {8'h1B, 8'hD8, 3'h2},
            {8'h18, 8'h01, 3'h3}, {8'h19, 8'h45, 3'h3}, {8'h1A, 8'h00, 3'h4},
            {8'h1B, 8'h8C, 3'h4}, {8'h80, 8'hD8, 3'h5}, {8'h81, 8'h1E, 3'h5},
            {8'h82, 8'h58, 3'h5}, {8'h83, 8'hD9, 3'h5}, {8'h1C, 8'h7F, 3'h6},
            {8'h1D, 8'h80, 3'h6}, {8'h80, 8'hD0, 3'h0}};
        for (int i = 0; i < 13; i++) begin
            run(tbl[i][18:11], tbl[i][10:3], 8'h42, 5'h0A, 1);
            chk(16'(o_res.cls), 16'(tbl[i][2:0]), "borrow class");
            chk(16'(o_res.flag_wr), tbl[i][2:0] == 3'h0 ? 16'h0 : 16'(xsd_pkg::FM_ARITH),
                "borrow flags");
            if (tbl[i][2:0] == 3'h5) chk(16'(o_res.sext), 16'(tbl[i][12]), "sign ext");
            if (tbl[i][2:0] inside {[3'h2:3'h4]})
                chk(16'(o_res.dir), 16'(tbl[i][12]), "direction");
        end
        axi_wr(xsd_pkg::ADDR_CTRL, 32'h3, r);
        run(8'h1D, 8'h12, 8'h34, 5'h00, 1);
        chk(16'(o_res.prot), 16'h1, "protected accumulator form");
        chk(16'(o_res.cls), 16'(xsd_pkg::XSD_SBB_ACC), "protected class");
        axi_wr(xsd_pkg::ADDR_CTRL, 32'h1, r);
        $display("test sbb done");
    endtask : t_sbb

    task automatic t_setcc();
        for (int c = 0; c < 16; c++) begin
            for (int f = 0; f < 32; f++) begin
                run(xsd_pkg::OP_ESC, 8'h90 | 8'(c), f[0] ? 8'h00 : 8'hC3, 5'(f), 1);
                chk(16'(o_res.cls), 16'(xsd_pkg::XSD_SETCC), "byte set class");
                chk(16'(o_res.cond), 16'(c), "condition code");
                chk(16'(o_res.set_byte), 16'(cond_true(4'(c), 5'(f))), "byte value");
                chk(16'(o_res.flag_wr), 16'h0, "flags untouched");
            end
        end
        run(xsd_pkg::OP_ESC, 8'h94, 8'hC8, 5'h04, 1);
        chk(16'(o_res.cls), 16'(xsd_pkg::XSD_ILLEGAL), "byte set bad reg");
        $display("test setcc done");
    endtask : t_setcc

    task automatic t_regs();
        logic [31:0] d0, d1;
        logic [1:0]  r;
        axi_rd(xsd_pkg::ADDR_CTRL, d0, r);
        chk(16'(d0[1:0]), 16'(xsd_pkg::CTRL_RST), "control reset");
        axi_rd(xsd_pkg::ADDR_RETIRED, d0, r);
        run(8'h1C, 8'h01, 8'h00, 5'h00, 1);
        axi_rd(xsd_pkg::ADDR_RETIRED, d1, r);
        chk(16'(d1 - d0), 16'h1, "retired count");
        axi_rd(xsd_pkg::ADDR_LAST, d1, r);
        chk(16'(d1[2:0]), 16'(xsd_pkg::XSD_SBB_ACC), "last class");
        axi_wr(4'hC, 32'h0, r);
        chk(16'(r), 16'(xsd_pkg::RESP_DECERR), "unmapped write");
        axi_rd(4'hC, d1, r);
        chk({14'h0, r}, 16'(xsd_pkg::RESP_DECERR), "unmapped read");
        chk(d1[15:0], 16'h0, "unmapped data");
        axi_wr(xsd_pkg::ADDR_CTRL, 32'h0, r);
        #1;
        chk(16'(o_ins_ready), 16'h0, "disabled refuses");
        axi_wr(xsd_pkg::ADDR_CTRL, 32'h1, r);
        chk(16'(r), 16'(xsd_pkg::RESP_OKAY), "control write");
        $display("test regs done");
    endtask : t_regs

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // ********************************************************
    // Main sequence and watchdog
    // ********************************************************
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_sar();
        t_sbb();
        t_setcc();
        end_of_test();
    end

    // Expected run is about a thousand cycles; this allows about a hundred times that
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end
endmodule : xsd_decode_tb
